// File: design/audio_serial_tx_status_flags.sv
// Transmit queue, serial shifter and status flags of an audio serial port.
// Assumes a classic Wishbone master and a bit clock arriving on a pin.
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "aud_tx_cfg.svh"
module audio_serial_tx_status_flags import aud_tx_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [3:0] rx_word_count_i,
	input wire logic link_bclk_i,
	output logic link_sd_o,
	output logic link_ws_o,
	output logic irq_o
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
		hit = (adr[7:2] == ofs[7:2]);
	endfunction

	logic ack_reg;
	logic [31:0] rdat_reg;
	logic [31:0] rmux;
	logic req;
	logic acc;
	logic wr_acc;
	logic rd_acc;
	logic [2:0] limit_reg;
	logic enable_reg;
	logic ovr_ie_reg;
	logic [3:0] mask_reg;
	logic [3:0] evt_reg;
	logic [3:0] evt_set;
	logic irq_reg;
	word_count_t count_reg;
	word_count_t count_next;
	ptr_t wr_ptr_reg;
	ptr_t rd_ptr_reg;
	logic [31:0] mem_rdata;
	logic push;
	logic push_ok;
	logic pop;
	logic tx_queue_empty;
	logic tx_queue_full;
	logic tx_level_low_flag;
	logic tx_overrun_flag;
	logic tx_starve_flag;
	logic tx_shift_active;
	logic rx_queue_empty;
	logic sts_wr;
	logic bclk_fall;
	shift_state_e state_reg;
	logic [4:0] bit_reg;
	logic [31:0] shreg;
	logic fetch_try;
	logic starve;

	// ----------------------------------------
	// Wishbone slave
	// ----------------------------------------
	// Access completes at the edge where ack is high
	assign req = wb_cyc_i & wb_stb_i;
	assign acc = req & ack_reg;
	assign wr_acc = acc & wb_we_i;
	assign rd_acc = acc & ~wb_we_i;
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;

	// Ack one cycle after the request, dropped next cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= req & ~ack_reg;
		end
	end

	// Read data captured with the ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_reg <= 32'h0;
		end else if (req & ~ack_reg & ~wb_we_i) begin
			rdat_reg <= rmux;
		end
	end

	// Read mux, unmapped offsets read zero; reserved bits zero
	always_comb begin
		rmux = 32'h0;
		if (hit(wb_adr_i, `OFS_CTRL)) begin
			rmux[2:0] = limit_reg;
			rmux[`CTRL_EN] = enable_reg;
			rmux[`CTRL_OVRIE] = ovr_ie_reg;
		end else if (hit(wb_adr_i, `OFS_EVENT)) begin
			rmux[3:0] = evt_reg;
		end else if (hit(wb_adr_i, `OFS_MASK)) begin
			rmux[3:0] = mask_reg;
		end else if (hit(wb_adr_i, `OFS_STATUS)) begin
			rmux[31:28] = count_reg;
			rmux[`STS_BUSY] = tx_shift_active;
			rmux[`STS_EMPTY] = tx_queue_empty;
			rmux[`STS_FULL] = tx_queue_full;
			rmux[`STS_LOW] = tx_level_low_flag;
			rmux[`STS_OVR] = tx_overrun_flag;
			rmux[`STS_STV] = tx_starve_flag;
			rmux[`STS_RX_QUEUE_EMPTY] = rx_queue_empty;
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	// Limit, enable, overrun interrupt enable and event mask
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			limit_reg <= `LIMIT_RST;
			enable_reg <= 1'b0;
			ovr_ie_reg <= 1'b0;
			mask_reg <= `MASK_RST;
		end else if (wr_acc) begin
			if (hit(wb_adr_i, `OFS_CTRL) && wb_sel_i[0]) begin
				limit_reg <= wb_dat_i[2:0];
				enable_reg <= wb_dat_i[`CTRL_EN];
			end
			if (hit(wb_adr_i, `OFS_CTRL) && wb_sel_i[1]) begin
				ovr_ie_reg <= wb_dat_i[`CTRL_OVRIE];
			end
			if (hit(wb_adr_i, `OFS_MASK) && wb_sel_i[0]) begin
				mask_reg <= wb_dat_i[3:0];
			end
		end
	end

	// ----------------------------------------
	// Transmit queue
	// ----------------------------------------
	// Push on data write, pop on shifter fetch
	assign push = wr_acc & hit(wb_adr_i, `OFS_TXDATA) & (|wb_sel_i);
	assign push_ok = push & ~tx_queue_full;
	assign tx_queue_empty = (count_reg == 4'h0);
	assign tx_queue_full = (count_reg == `TX_DEPTH);
	assign count_next = count_reg + {3'h0, push_ok} - {3'h0, pop};

	// Word count and pointers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_reg <= 4'h0;
			wr_ptr_reg <= 3'h0;
			rd_ptr_reg <= 3'h0;
		end else begin
			count_reg <= count_next;
			if (push_ok) begin
				wr_ptr_reg <= wr_ptr_reg + 3'h1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 3'h1;
			end
		end
	end

	tx_word_mem u_mem (
		.clk_i(clk_i),
		.we_i(push_ok),
		.waddr_i(wr_ptr_reg),
		.wdata_i(wb_dat_i),
		.raddr_i(rd_ptr_reg),
		.rdata_o(mem_rdata)
	);

	// ----------------------------------------
	// Serial shifter
	// ----------------------------------------
	link_edge_sync u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(link_bclk_i),
		.fall_o(bclk_fall)
	);

	// Fetch at start of stream or at end of each word
	assign fetch_try = bclk_fall & enable_reg
		& ((state_reg == SH_IDLE) ? ~tx_queue_empty : (bit_reg == `LAST_BIT));
	assign pop = fetch_try & ~tx_queue_empty;
	assign starve = fetch_try & tx_queue_empty;
	assign tx_shift_active = (state_reg == SH_RUN);
	assign link_sd_o = shreg[31];
	assign link_ws_o = bit_reg[4];

	// Shift out on falling link clock edges
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= SH_IDLE;
			bit_reg <= 5'h0;
			shreg <= 32'h0;
		end else if (pop) begin
			state_reg <= SH_RUN;
			bit_reg <= 5'h0;
			shreg <= mem_rdata;
		end else if (bclk_fall && state_reg == SH_RUN) begin
			if (bit_reg == `LAST_BIT) begin
				state_reg <= SH_IDLE;
				bit_reg <= 5'h0;
				shreg <= 32'h0;
			end else begin
				bit_reg <= bit_reg + 5'h1;
				shreg <= {shreg[30:0], 1'b0};
			end
		end
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	assign rx_queue_empty = (rx_word_count_i == 4'h0);
	assign sts_wr = wr_acc & hit(wb_adr_i, `OFS_STATUS) & wb_sel_i[2];

	// Threshold flag, cleared only by a lifting data write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_level_low_flag <= 1'b1;
		end else if (count_next <= {1'b0, limit_reg}) begin
			tx_level_low_flag <= 1'b1;
		end else if (push_ok) begin
			tx_level_low_flag <= 1'b0;
		end
	end

	// Sticky errors, a set beats a write-one clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_overrun_flag <= 1'b0;
			tx_starve_flag <= 1'b0;
		end else begin
			tx_overrun_flag <= (push & tx_queue_full)
				| (tx_overrun_flag & ~(sts_wr & wb_dat_i[`STS_OVR]));
			tx_starve_flag <= starve
				| (tx_starve_flag & ~(sts_wr & wb_dat_i[`STS_STV]));
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	assign irq_o = irq_reg;
	always_comb begin
		evt_set = 4'h0;
		evt_set[`EVT_OVR] = push & tx_queue_full;
		evt_set[`EVT_STV] = starve;
		evt_set[`EVT_LOW] = ~tx_level_low_flag & (count_next <= {1'b0, limit_reg});
		evt_set[`EVT_DONE] = tx_shift_active & bclk_fall & (bit_reg == `LAST_BIT) & ~pop;
	end

	// Read clears only the bits it returned; later events survive
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			evt_reg <= 4'h0;
		end else if (rd_acc && hit(wb_adr_i, `OFS_EVENT)) begin
			evt_reg <= (evt_reg & ~rdat_reg[3:0]) | evt_set;
		end else begin
			evt_reg <= evt_reg | evt_set;
		end
	end

	// Level interrupt output
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= (|(evt_reg & mask_reg)) | (ovr_ie_reg & tx_overrun_flag);
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_status_read;
		req && !ack_reg && !wb_we_i && hit(wb_adr_i, `OFS_STATUS);
	endsequence

	sequence s_last_bit_empty;
		tx_shift_active && bclk_fall && bit_reg == `LAST_BIT && tx_queue_empty;
	endsequence

	a_busy_on_load: assert property (
		(state_reg == SH_IDLE && pop) |=> tx_shift_active ##1 link_ws_o == 1'b0)
		else $error("busy did not rise on first load");

	a_busy_drop: assert property (
		s_last_bit_empty |=> !tx_shift_active)
		else $error("busy stayed high after queue drained");

	a_empty_track: assert property (
		(push_ok && !pop) |=> !tx_queue_empty && count_reg == $past(count_reg) + 4'h1)
		else $error("empty flag or count wrong after push");

	a_full_track: assert property (
		(count_reg == 4'h7 && push_ok && !pop) |=> tx_queue_full)
		else $error("full flag missing at eight words");

	a_low_set: assert property (
		(count_next <= {1'b0, limit_reg}) |=> tx_level_low_flag)
		else $error("threshold flag not set at or below limit");

	a_low_hold: assert property (
		(tx_level_low_flag && !push_ok) |=> tx_level_low_flag)
		else $error("threshold flag cleared without data write");

	a_ovr_set: assert property (
		(push && tx_queue_full) |=> tx_overrun_flag [*2])
		else $error("overrun flag not set or not sticky");

	a_stv_set: assert property (
		starve |=> tx_starve_flag)
		else $error("starve flag not set on empty fetch");

	a_rx_empty: assert property (
		s_status_read |=> wb_ack_o && wb_dat_o[`STS_RX_QUEUE_EMPTY] == $past(rx_queue_empty))
		else $error("receive empty bit wrong");

	a_count_read: assert property (
		s_status_read |=> wb_dat_o[31:28] == $past(count_reg) && wb_dat_o[31:28] <= 4'h8)
		else $error("word count field wrong");

	a_ovr_irq: assert property (
		(ovr_ie_reg && tx_overrun_flag) |=> irq_o)
		else $error("overrun interrupt not raised");

	a_rsvd_zero: assert property (
		s_status_read |=> wb_dat_o[15:13] == 3'h0)
		else $error("reserved status bits not zero");
endmodule // audio_serial_tx_status_flags

// File: design/aud_tx_cfg.svh
// Offsets, field positions, reset values and limits of the audio transmit
// status block. Assumes a 32-bit classic Wishbone bus with byte addresses.
// Contract
// - Busy flag bit 21 rises on first shift load, falls when all shifted out
// - Bit 20 is high exactly when the transmit queue holds no words
// - Bit 19 is high exactly when the transmit queue holds eight words
// - Bit 18 is set while word count is at or below the limit field
// - Bit 18 clears only after a data write lifts the count above limit
// - Bit 17 sets on a data write to a full queue; write 1 clears it
// - Bit 16 sets when the shifter fetches from an empty queue; write 1 clears
// - Bit 12 is high exactly when the receive queue holds no words
// - Bits 31:28 report the transmit word count in binary, zero to eight
// - Interrupt requested when overrun enable and overrun flag are both one
`ifndef AUD_TX_CFG_SVH
`define AUD_TX_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_TXDATA 8'h04
`define OFS_EVENT 8'h08
`define OFS_STATUS 8'h0c
`define OFS_MASK 8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define STS_CNT_LSB 28
`define STS_BUSY 21
`define STS_EMPTY 20
`define STS_FULL 19
`define STS_LOW 18
`define STS_OVR 17
`define STS_STV 16
`define STS_RX_QUEUE_EMPTY 12
`define CTRL_EN 4
`define CTRL_OVRIE 9
`define EVT_OVR 0
`define EVT_STV 1
`define EVT_LOW 2
`define EVT_DONE 3

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define LIMIT_RST 3'h0
`define MASK_RST 4'h0
`define TX_DEPTH 4'h8
`define LAST_BIT 5'h1f

`endif

// File: design/aud_tx_pkg.sv
// Types shared by the audio transmit status block.
// Assumes nothing beyond a SystemVerilog tool.
package aud_tx_pkg;
	// Shifter states
	typedef enum logic {SH_IDLE, SH_RUN} shift_state_e;
	typedef logic [3:0] word_count_t;
	typedef logic [2:0] ptr_t;
endpackage

// File: design/link_edge_sync.sv
// Two-flop synchroniser and edge finder for the link bit clock.
// Assumes the link clock is far slower than clk_i.
`timescale 1ns/1ps
module link_edge_sync (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic pin_i,
	output logic fall_o
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	// Only sync_reg reads meta_reg
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// Start at the idle high level of the bit clock, so no false edge
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
			last_reg <= 1'b1;
			fall_o <= 1'b0;
		end else begin
			meta_reg <= pin_i;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
			fall_o <= last_reg & ~sync_reg;
		end
	end
endmodule // link_edge_sync

// File: design/tx_word_mem.sv
// Eight-word transmit store with registered read data.
// Assumes one writer and one reader on clk_i.
`timescale 1ns/1ps
module tx_word_mem import aud_tx_pkg::*; (
	input wire logic clk_i,
	input wire logic we_i,
	input wire ptr_t waddr_i,
	input wire logic [31:0] wdata_i,
	input wire ptr_t raddr_i,
	output logic [31:0] rdata_o
);
	logic [31:0] mem [0:7];

	// Write port
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	// Read with bypass so a fresh word is seen next cycle
	always_ff @(posedge clk_i) begin
		if (we_i && waddr_i == raddr_i) begin
			rdata_o <= wdata_i;
		end else begin
			rdata_o <= mem[raddr_i];
		end
	end
endmodule // tx_word_mem

// File: testbench/codec_model.sv
// Behavioural audio codec on the far side of the serial link.
// Assumes the bench starts and stops the bit clock with run_i.
`timescale 1ns/1ps
module codec_model (
	input wire logic run_i,
	input wire logic sd_i,
	input wire logic ws_i,
	output logic bclk_o,
	output logic [31:0] word_o,
	output logic done_o,
	output logic ws_bad_o
);
	int falls;
	initial begin
		bclk_o = 1'b1;
		word_o = 32'h0;
		done_o = 1'b0;
		ws_bad_o = 1'b0;
		falls = 0;
	end
	// Bit clock, 320 ns, parks high outside frames
	always begin
		#160;
		if (run_i || !bclk_o) begin
			bclk_o = ~bclk_o;
		end
	end
	// Capture first word MSB first, check channel select per half
	always @(negedge bclk_o) begin
		falls++;
		if (falls >= 2 && falls <= 33) begin
			word_o[33 - falls] = sd_i;
			if (ws_i !== (falls > 17)) begin
				ws_bad_o = 1'b1;
			end
		end
		if (falls == 33) begin
			done_o = 1'b1;
		end
	end
endmodule // codec_model

// File: testbench/tb_top.sv
// Self-checking bench for the audio transmit status block.
// Assumes the design files and the codec model are compiled first.
`timescale 1ns/1ps
`include "aud_tx_cfg.svh"
module tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0;
	logic [31:0] rd;
	logic ack;
	logic [3:0] rxc = 4'h0;
	logic bclk, sd, ws, irq, run = 1'b0;
	logic [31:0] word, q;
	logic done, ws_bad;
	int bad_count = 0;
	int cmp_count = 0;

	// Clock, 25 MHz
	always #20 clk_i = ~clk_i;

	audio_serial_tx_status_flags DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(rd), .wb_ack_o(ack), .rx_word_count_i(rxc), .link_bclk_i(bclk),
		.link_sd_o(sd), .link_ws_o(ws), .irq_o(irq));
	codec_model codec (.run_i(run), .sd_i(sd), .ws_i(ws), .bclk_o(bclk), .word_o(word),
		.done_o(done), .ws_bad_o(ws_bad));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic conclude();
		$display("Compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One classic Wishbone cycle, waits for ack under a bound
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hf;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) begin
			bad_count++;
			conclude();
		end
	endtask

	function automatic logic [31:0] st(input logic [3:0] c, input logic low, ovr, stv, busy,
		rxe);
		return {c, 6'h0, busy, c == 4'h0, c == 4'h8, low, ovr, stv, 3'h0, rxe, 12'h0};
	endfunction

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		wb(1'b0, `OFS_STATUS, 32'h0);
		chk(q, 32'h0014_1000);
		wb(1'b1, `OFS_STATUS, 32'hffff_ffff);
		wb(1'b0, `OFS_STATUS, 32'h0);
		chk(q, 32'h0014_1000);
		rxc <= 4'h3;
		wb(1'b0, `OFS_STATUS, 32'h0);
		chk(q, 32'h0014_0000);
		rxc <= 4'h0;
		wb(1'b0, 8'h20, 32'h0);
		chk(q, 32'h0);
		$display("reset test done");
	endtask

	task automatic t_fill();
		wb(1'b1, `OFS_CTRL, 32'h0000_0202);
		wb(1'b0, `OFS_CTRL, 32'h0);
		chk(q, 32'h0000_0202);
		for (int i = 1; i <= 8; i++) begin
			wb(1'b1, `OFS_TXDATA, 32'hc3a5_0000 | i);
			wb(1'b0, `OFS_STATUS, 32'h0);
			chk(q, st(i[3:0], i <= 2, 1'b0, 1'b0, 1'b0, 1'b1));
		end
		chk({31'h0, irq}, 32'h0);
		wb(1'b1, `OFS_TXDATA, 32'hdead_0009);
		wb(1'b0, `OFS_STATUS, 32'h0);
		chk(q, st(4'h8, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1));
		chk({31'h0, irq}, 32'h1);
		wb(1'b1, `OFS_MASK, 32'h1);
		wb(1'b1, `OFS_STATUS, 32'h0002_0000);
		wb(1'b0, `OFS_STATUS, 32'h0);
		chk(q, st(4'h8, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1));
		chk({31'h0, irq}, 32'h1);
		wb(1'b0, `OFS_EVENT, 32'h0);
		chk(q & 32'h1, 32'h1);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq}, 32'h0);
		wb(1'b1, `OFS_MASK, 32'h0);
		$display("fill test done");
	endtask

	task automatic t_stream();
		int n;
		wb(1'b1, `OFS_CTRL, 32'h0000_0012);
		run <= 1'b1;
		n = 0;
		while (done !== 1'b1 && n < 400) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 400) begin
			bad_count++;
			conclude();
		end
		chk(word, 32'hc3a5_0001);
		chk({31'h0, ws_bad}, 32'h0);
		wb(1'b0, `OFS_STATUS, 32'h0);
		chk(q & 32'h0020_0000, 32'h0020_0000);
		n = 0;
		do begin
			wb(1'b0, `OFS_STATUS, 32'h0);
			n++;
		end while (q[`STS_BUSY] !== 1'b0 && n < 1500);
		if (n >= 1500) begin
			bad_count++;
			conclude();
		end
		chk(q, st(4'h0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1));
		// Threshold rise, starve and transmit done events, overrun already cleared
		wb(1'b0, `OFS_EVENT, 32'h0);
		chk(q, 32'h0000_000e);
		run <= 1'b0;
		wb(1'b1, `OFS_CTRL, 32'h0000_0002);
		wb(1'b1, `OFS_STATUS, 32'h0001_0000);
		wb(1'b0, `OFS_STATUS, 32'h0);
		chk(q, 32'h0014_1000);
		$display("stream test done");
	endtask

	// Main sequence
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_fill();
		t_stream();
		conclude();
	end
endmodule // tb_top
